// >>> inc/key_guard_if.sv
// request/answer link between the slot controller and the key slot guard
// assumes both ends run on the same sys_clk
`timescale 1ns/10ps
`default_nettype none
interface key_guard_if;
   import key_guard_pkg::*;
   logic req;
   cmd_t cmd;
   logic [7:0] slot;
   logic [1:0] word;
   logic [31:0] wdata;
   logic flash_wen;
   logic ack;
   logic [31:0] rdata;
   logic evt_pushed;
   logic evt_revoked;
   logic evt_error;
   logic stat_selected;
   logic stat_blocked;

   modport guard (input req, cmd, slot, word, wdata, flash_wen,
                  output ack, rdata, evt_pushed, evt_revoked, evt_error, stat_selected, stat_blocked);
   modport host (output req, cmd, slot, word, wdata, flash_wen,
                 input ack, rdata, evt_pushed, evt_revoked, evt_error, stat_selected, stat_blocked);
endinterface : key_guard_if
`default_nettype wire

// >>> inc/key_guard_pkg.sv
// shared constants, field positions and enumerations for the key slot guard
// and its controller; assumes the guard and controller share one clock
package key_guard_pkg;

   localparam int NUM_SLOTS = 128;
   localparam int WORDS = 4;
   localparam int IDX_W = 7;
   localparam int DATA_W = 32;

   localparam logic [7:0] NO_SLOT = 8'h00;
   localparam logic [7:0] FIRST_SLOT_ID = 8'h01;
   localparam logic [7:0] LAST_SLOT_ID = 8'h80;
   localparam logic [7:0] SELECT_RESET = 8'h00;

   localparam logic [31:0] ERASED_WORD = 32'hffffffff;
   localparam logic [31:0] BLOCKED_WORD = 32'hdeaddead;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   localparam logic [31:0] WORD_STRIDE = 32'h00000004;
   localparam logic [1:0] LAST_WORD = 2'h3;

   // permission word bit positions
   localparam int PERM_WRITE_BIT = 0;
   localparam int PERM_READ_BIT = 1;
   localparam int PERM_EXPORT_BIT = 2;
   localparam int PERM_LIVE_BIT = 3;

   typedef enum logic [2:0] {
      CMD_SELECT = 3'b000,
      CMD_DEST_WR = 3'b001,
      CMD_VAL_WR = 3'b010,
      CMD_PERM_WR = 3'b011,
      CMD_VAL_RD = 3'b100,
      CMD_HDR_RD = 3'b101,
      CMD_EXPORT = 3'b110
   } cmd_t;

   typedef enum logic [1:0] {
      OP_PROGRAM = 2'b00,
      OP_READ = 2'b01,
      OP_EXPORT = 2'b10,
      OP_REVOKE = 2'b11
   } host_op_t;

   // controller sequence steps
   localparam logic [2:0] STEP_FIRST = 3'h0;
   localparam logic [2:0] STEP_SECOND = 3'h1;
   localparam logic [2:0] PROG_LAST_VAL_STEP = 3'h5;
   localparam logic [2:0] PROG_PERM_STEP = 3'h6;
   localparam logic [2:0] READ_LAST_VAL_STEP = 3'h4;
   localparam logic [2:0] PROG_WORD_BASE = 3'h2;
   localparam logic [2:0] READ_WORD_BASE = 3'h1;

   // controller wishbone map
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_DEST = 8'h04;
   localparam logic [7:0] ADR_PERM = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h0c;
   localparam logic [7:0] ADR_DATA0 = 8'h10;
   localparam logic [7:0] ADR_DATA_LAST = 8'h1c;
   localparam int CTRL_OP_LSB = 0;
   localparam int CTRL_SLOT_LSB = 8;
   localparam int STAT_BUSY = 0;
   localparam int STAT_SELECTED = 1;
   localparam int STAT_BLOCKED = 2;
   localparam int STAT_PUSHED = 3;
   localparam int STAT_REVOKED = 4;
   localparam int STAT_ERROR = 5;

endpackage : key_guard_pkg

// >>> tb/key_link_checker.sv
// assertions on the host/guard link
// assumes one clock; placed beside the link
`timescale 1ns/10ps
`default_nettype none
module key_link_checker
   import key_guard_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic reset_n, // reset
   input wire logic req, // request
   input wire cmd_t cmd, // command
   input wire logic [7:0] slot, // slot id
   input wire logic ack, // answer
   input wire logic [31:0] rdata, // read data
   input wire logic evt_pushed, // done
   input wire logic evt_revoked, // revoked
   input wire logic evt_error, // error
   input wire logic stat_selected, // accessed
   input wire logic stat_blocked // violation
);
   logic [7:0] sel_reg;
   wire logic take = req && !ack;
   // shadow of the selection, so slot mismatches can be judged here
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         sel_reg <= NO_SLOT;
      else if (take && cmd == CMD_SELECT)
         sel_reg <= (slot > LAST_SLOT_ID) ? NO_SLOT : slot;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence s_sel; take && cmd == CMD_SELECT; endsequence
   sequence s_val; take && (cmd == CMD_VAL_RD || cmd == CMD_VAL_WR); endsequence
   AST_ACK: assert property (take |=> ack) else $error("no ack");
   AST_ACK_PULSE: assert property (ack |=> !ack) else $error("long ack");
   AST_SEL_CLR: assert property (s_sel ##0 slot inside {[FIRST_SLOT_ID:LAST_SLOT_ID]}
      |=> !stat_selected && !stat_blocked) else $error("flags kept");
   AST_BAD_SEL: assert property (s_sel ##0 slot > LAST_SLOT_ID |=> stat_blocked) else $error("bad select");
   AST_OTHER: assert property (s_val ##0 slot != sel_reg |=> stat_blocked) else $error("other slot");
   AST_DEAD: assert property (s_val ##0 cmd == CMD_VAL_RD && slot != sel_reg
      |=> rdata == BLOCKED_WORD) else $error("read leaked");
   AST_HIT: assert property (s_val ##0 slot == sel_reg ##1 !stat_blocked |-> stat_selected) else $error("no hit");
   AST_EXP_ERR: assert property (take && cmd == CMD_EXPORT && sel_reg == NO_SLOT |=> evt_error)
      else $error("no error");
   AST_ONE_EVT: assert property ($onehot0({evt_pushed, evt_revoked, evt_error})) else $error("two events");
   AST_PUSH_PULSE: assert property (evt_pushed |=> !evt_pushed) else $error("long event");
endmodule : key_link_checker
`default_nettype wire

// >>> tb/testbench.sv
// bench: host and guard joined by the link, apb target answered here
// assumes one 125 MHz clock and a sync active-low reset
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
   import key_guard_pkg::*;
;
   localparam logic [31:0] DST = 32'h40000000;
   logic sys_clk = 0, reset_n = 0, cyc = 0, stb = 0, we = 0, pready = 0, perr = 0, psel, penable, pwrite, ack;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, q, dat_o, paddr, pwdata, cap[$];
   logic [31:0] key[4] = '{32'h13579bdf, 32'h2468ace0, 32'h0f1e2d3c, 32'h4b5a6978};
   logic [31:0] dead[4] = '{4{BLOCKED_WORD}};
   int num_errors = 0, total_checks = 0;
   key_guard_if kg();
   key_slot_host i_key_slot_host(.sys_clk, .reset_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack), .kg(kg.host));
   key_slot_guard i_key_slot_guard(.sys_clk, .reset_n, .kg(kg.guard), .psel, .penable, .pwrite,
      .paddr, .pwdata, .pready, .pslverr(perr));
   key_link_checker i_key_link_checker(.sys_clk, .reset_n, .req(kg.req), .cmd(kg.cmd), .slot(kg.slot),
      .ack(kg.ack), .rdata(kg.rdata), .evt_pushed(kg.evt_pushed), .evt_revoked(kg.evt_revoked),
      .evt_error(kg.evt_error), .stat_selected(kg.stat_selected), .stat_blocked(kg.stat_blocked));
   initial forever #4 sys_clk = ~sys_clk;
   // one wait state per apb write, so the guard must really hold its access
   always @(posedge sys_clk)
   begin
      pready <= psel && penable && !pready;
      if (psel && penable && pready && pwrite)
         cap.push_back(paddr);
      if (psel && penable && pready && pwrite)
         cap.push_back(pwdata);
   end
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge sys_clk); while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : wb
   task automatic op(input logic [1:0] o, input logic [7:0] s);
      wb(1'b1, ADR_STAT, 32'h0000003f);
      wb(1'b1, ADR_CTRL, {16'h0, s, 6'h0, o});
      do wb(1'b0, ADR_STAT, 32'h0); while (q[STAT_BUSY] !== 1'b0);
   endtask : op
   task automatic rd(input logic [7:0] s, input logic [31:0] e[4]);
      op(OP_READ, s);
      for (int i = 0; i < WORDS; i++)
      begin
         wb(1'b0, ADR_DATA0 + 8'(4 * i), 32'h0);
         `CHK(q, e[i])
      end
   endtask : rd
   task automatic t_empty;
      rd(8'h09, '{4{ERASED_WORD}});
      op(OP_EXPORT, 8'h09);
      `CHK(q[STAT_ERROR], 1'b1)
      rd(8'hc8, dead);
      op(OP_EXPORT, 8'h00);
      `CHK(q[STAT_ERROR], 1'b1)
      $display("empty and bad slots done");
   endtask : t_empty
   task automatic t_prog;
      wb(1'b1, ADR_DEST, DST);
      wb(1'b1, ADR_PERM, 32'h0000000e);
      for (int i = 0; i < WORDS; i++)
         wb(1'b1, ADR_DATA0 + 8'(4 * i), key[i]);
      op(OP_PROGRAM, 8'h05);
      rd(8'h05, key);
      wb(1'b1, ADR_DATA0, 32'h0);
      op(OP_PROGRAM, 8'h05);
      rd(8'h05, key);
      $display("program and read done");
   endtask : t_prog
   task automatic t_push;
      cap.delete();
      op(OP_EXPORT, 8'h05);
      `CHK(q[STAT_PUSHED], 1'b1)
      `CHK(cap.size(), 8)
      for (int i = 0; i < WORDS; i++)
      begin
         `CHK(cap[2 * i], DST + 32'(4 * i))
         `CHK(cap[2 * i + 1], key[i])
      end
      $display("export done");
   endtask : t_push
   // second half of a long key: same header, target four words further on
   task automatic t_split;
      wb(1'b1, ADR_DEST, DST + 32'h00000010);
      op(OP_PROGRAM, 8'h06);
      op(OP_EXPORT, 8'h06);
      `CHK(cap.size(), 16)
      for (int i = 0; i < WORDS; i++)
         `CHK(cap[8 + 2 * i], DST + 32'h00000010 + 32'(4 * i))
      // target answers the first write with an error: sequence must stop there
      perr <= 1'b1;
      op(OP_EXPORT, 8'h06);
      perr <= 1'b0;
      `CHK(q[STAT_ERROR], 1'b1)
      `CHK(q[STAT_PUSHED], 1'b0)
      `CHK(cap.size(), 18)
      $display("split key and apb error done");
   endtask : t_split
   task automatic t_revoke;
      wb(1'b1, ADR_PERM, 32'h00000006);
      op(OP_REVOKE, 8'h05);
      rd(8'h05, dead);
      op(OP_EXPORT, 8'h05);
      `CHK(q[STAT_REVOKED], 1'b1)
      `CHK(cap.size(), 18)
      $display("revoke done");
   endtask : t_revoke
   task automatic report_and_stop;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      report_and_stop;
   end
   initial
   begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_empty;
      t_prog;
      t_push;
      t_split;
      t_revoke;
      report_and_stop;
   end
endmodule : testbench
`default_nettype wire

// >>> verilog/key_slot_guard.sv
// key slot guard: emulated key store with per-slot policy and export over apb
// assumes a controller on key_guard_if and an apb slave on the same clock
//
// Function
// - only the selected slot is accessed, per policy; header reads take any slot id
// - selection resets to zero; ids 1..128
// - successful selected access sets accessed flag
// - wrong slot, failed select, blocks set violation
// - selection write of id 0..128 clears both status flags
// - erased slot: ones value, no target, everything allowed except export
// - software deselects slot when finished
// - program order: select, target, words, policy, deselect
// - block writes: none selected, programmed, occupied
// - long keys span slots, target advances four words
// - readable slot without target: clear export bit
// - flash write enabled only while programming or revoking
// - live readable slot returns stored words
// - blocked reads return dead marker
// - export writes value to slot target
// - clean export raises export-done event
// - bad export raises export-error event
// - export of revoked slot raises revoked event
// - revoked slot refuses read and export
// - revocation zeroes stored value words
// - revocation leaves delivered keys alone
// - policy bits one enabled; erased forbids export
`timescale 1ns/10ps
`default_nettype none
module key_slot_guard
   import key_guard_pkg::*;
(
   input wire logic sys_clk,           // device clock
   input wire logic reset_n,           // synchronous reset
   key_guard_if.guard kg,              // controller link
   output logic psel,                  // apb select
   output logic penable,               // apb enable
   output logic pwrite,                // apb write
   output logic [31:0] paddr,          // apb address
   output logic [31:0] pwdata,         // apb write data
   input wire logic pready,            // apb ready
   input wire logic pslverr            // apb error
);

   typedef enum logic [1:0] {
      EX_IDLE = 2'b00,
      EX_SETUP = 2'b01,
      EX_ACCESS = 2'b10
   } export_state_t;

   function automatic logic [IDX_W-1:0] slot_index(input logic [7:0] id);
      slot_index = IDX_W'(id - FIRST_SLOT_ID);
   endfunction : slot_index

   logic [31:0] slot_secret_words [NUM_SLOTS][WORDS];
   logic [31:0] export_target_addr [NUM_SLOTS];
   logic [31:0] slot_policy_word [NUM_SLOTS];
   logic [7:0] slot_choice_reg;
   logic stat_sel_reg;
   logic stat_blk_reg;
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic revoked_evt_reg;
   logic chk_err_reg;
   logic apb_err_reg;
   logic pushed_reg;
   export_state_t ex_state_reg;
   logic [IDX_W-1:0] ex_slot_reg;
   logic [1:0] ex_word_reg;
   logic [31:0] paddr_reg;
   logic [31:0] pwdata_reg;

   wire take = kg.req & ~ack_reg;
   wire [IDX_W-1:0] tgt_idx = slot_index(kg.slot);
   wire [IDX_W-1:0] sel_idx = slot_index(slot_choice_reg);
   wire [31:0] sel_perm = slot_policy_word[sel_idx];
   wire [31:0] sel_dest = export_target_addr[sel_idx];
   wire slot_on = slot_choice_reg != NO_SLOT;
   wire tgt_match = slot_on && (kg.slot == slot_choice_reg);
   wire slot_empty = sel_perm == ERASED_WORD;
   wire id_valid = (kg.slot == NO_SLOT) || (kg.slot <= LAST_SLOT_ID);
   wire loc_empty = (kg.cmd == CMD_DEST_WR) ? (sel_dest == ERASED_WORD)
                                            : (slot_secret_words[sel_idx][kg.word] == ERASED_WORD);
   // programming only into an erased header, erased word, with flash writing on
   wire wr_ok = tgt_match && kg.flash_wen && sel_perm[PERM_WRITE_BIT] && slot_empty && loc_empty;
   // a programmed header may still take a cleared live bit (revocation)
   wire perm_ok = tgt_match && kg.flash_wen && (slot_empty || !kg.wdata[PERM_LIVE_BIT]);
   wire [31:0] perm_new = slot_empty ? kg.wdata : (sel_perm & kg.wdata);
   wire rd_ok = tgt_match && sel_perm[PERM_LIVE_BIT] && sel_perm[PERM_READ_BIT];
   wire ex_busy = ex_state_reg != EX_IDLE;
   wire ex_revoked = slot_on && !sel_perm[PERM_LIVE_BIT];
   // erased header counts as default permissions: never exportable
   wire ex_bad = !slot_on || (sel_dest == ERASED_WORD) || slot_empty || !sel_perm[PERM_EXPORT_BIT];
   wire ex_start = take && (kg.cmd == CMD_EXPORT) && !ex_busy && !ex_revoked && !ex_bad;

   // register side: selection, status, storage, cpu reads
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         slot_choice_reg <= SELECT_RESET;
         stat_sel_reg <= 1'b0;
         stat_blk_reg <= 1'b0;
         ack_reg <= 1'b0;
         rdata_reg <= ZERO_WORD;
         revoked_evt_reg <= 1'b0;
         chk_err_reg <= 1'b0;
         for (int s = 0; s < NUM_SLOTS; s++)
         begin
            export_target_addr[s] <= ERASED_WORD;
            slot_policy_word[s] <= ERASED_WORD;
            for (int w = 0; w < WORDS; w++)
               slot_secret_words[s][w] <= ERASED_WORD;
         end
      end
      else
      begin
         ack_reg <= take;
         revoked_evt_reg <= 1'b0;
         chk_err_reg <= 1'b0;
         if (take)
         begin
            unique case (kg.cmd)
               CMD_SELECT:
               begin
                  slot_choice_reg <= id_valid ? kg.slot : NO_SLOT;
                  stat_sel_reg <= 1'b0;
                  stat_blk_reg <= !id_valid;
               end
               CMD_DEST_WR, CMD_VAL_WR:
               begin
                  if (wr_ok)
                  begin
                     if (kg.cmd == CMD_DEST_WR)
                        export_target_addr[sel_idx] <= kg.wdata;
                     else
                        slot_secret_words[sel_idx][kg.word] <= kg.wdata;
                     stat_sel_reg <= 1'b1;
                  end
                  else
                     stat_blk_reg <= 1'b1;
               end
               CMD_PERM_WR:
               begin
                  if (perm_ok)
                  begin
                     slot_policy_word[sel_idx] <= perm_new;
                     stat_sel_reg <= 1'b1;
                     // zeroize locally only; keys already exported stay put
                     if (!perm_new[PERM_LIVE_BIT])
                        for (int w = 0; w < WORDS; w++)
                           slot_secret_words[sel_idx][w] <= ZERO_WORD;
                  end
                  else
                     stat_blk_reg <= 1'b1;
               end
               CMD_VAL_RD:
               begin
                  rdata_reg <= rd_ok ? slot_secret_words[sel_idx][kg.word] : BLOCKED_WORD;
                  if (rd_ok)
                     stat_sel_reg <= 1'b1;
                  else
                     stat_blk_reg <= 1'b1;
               end
               CMD_HDR_RD:
                  rdata_reg <= kg.word[0] ? slot_policy_word[tgt_idx] : export_target_addr[tgt_idx];
               CMD_EXPORT:
               begin
                  // a request during a running export is dropped silently
                  if (!ex_busy)
                  begin
                     chk_err_reg <= !slot_on || (!ex_revoked && ex_bad);
                     revoked_evt_reg <= ex_revoked;
                  end
               end
               default:
               begin
                  stat_blk_reg <= 1'b1;
               end
            endcase
         end
      end
   end

   // export engine: four apb writes, lowest word first
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         ex_state_reg <= EX_IDLE;
         ex_slot_reg <= '0;
         ex_word_reg <= '0;
         paddr_reg <= ZERO_WORD;
         pwdata_reg <= ZERO_WORD;
         pushed_reg <= 1'b0;
         apb_err_reg <= 1'b0;
      end
      else
      begin
         pushed_reg <= 1'b0;
         apb_err_reg <= 1'b0;
         unique case (ex_state_reg)
            EX_IDLE:
            begin
               if (ex_start)
               begin
                  ex_slot_reg <= sel_idx;
                  ex_word_reg <= '0;
                  paddr_reg <= sel_dest;
                  pwdata_reg <= slot_secret_words[sel_idx][0];
                  ex_state_reg <= EX_SETUP;
               end
            end
            EX_SETUP:
               ex_state_reg <= EX_ACCESS;
            EX_ACCESS:
            begin
               if (pready)
               begin
                  if (pslverr)
                  begin
                     apb_err_reg <= 1'b1;
                     ex_state_reg <= EX_IDLE;
                  end
                  else if (ex_word_reg == LAST_WORD)
                  begin
                     pushed_reg <= 1'b1;
                     ex_state_reg <= EX_IDLE;
                  end
                  else
                  begin
                     ex_word_reg <= ex_word_reg + 2'h1;
                     paddr_reg <= paddr_reg + WORD_STRIDE;
                     pwdata_reg <= slot_secret_words[ex_slot_reg][ex_word_reg + 2'h1];
                     ex_state_reg <= EX_SETUP;
                  end
               end
            end
            default:
               ex_state_reg <= EX_IDLE;
         endcase
      end
   end

   assign psel = ex_state_reg != EX_IDLE;
   assign penable = ex_state_reg == EX_ACCESS;
   assign pwrite = psel;
   assign paddr = paddr_reg;
   assign pwdata = pwdata_reg;

   assign kg.ack = ack_reg;
   assign kg.rdata = rdata_reg;
   assign kg.evt_pushed = pushed_reg;
   assign kg.evt_revoked = revoked_evt_reg;
   assign kg.evt_error = chk_err_reg | apb_err_reg;
   assign kg.stat_selected = stat_sel_reg;
   assign kg.stat_blocked = stat_blk_reg;

endmodule : key_slot_guard
`default_nettype wire

// >>> verilog/key_slot_host.sv
// slot controller: runs whole program/read/export/revoke sequences on the guard
// software reaches it as a classic wishbone slave on the same clock
`timescale 1ns/10ps
`default_nettype none
module key_slot_host
   import key_guard_pkg::*;
(
   input wire logic sys_clk,           // device clock
   input wire logic reset_n,           // synchronous reset
   input wire logic wb_cyc_i,          // wishbone cycle
   input wire logic wb_stb_i,          // wishbone strobe
   input wire logic wb_we_i,           // wishbone write
   input wire logic [7:0] wb_adr_i,    // wishbone byte address
   input wire logic [31:0] wb_dat_i,   // wishbone write data
   input wire logic [3:0] wb_sel_i,    // wishbone byte enables
   output logic [31:0] wb_dat_o,       // wishbone read data
   output logic wb_ack_o,              // wishbone ack
   key_guard_if.host kg                // guard link
);

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_REQ = 2'b01,
      H_WAIT = 2'b10
   } host_state_t;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
      for (int b = 0; b < 4; b++)
         merge_bytes[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
   endfunction : merge_bytes

   function automatic cmd_t step_cmd(input host_op_t op, input logic [2:0] step);
      step_cmd = CMD_SELECT;
      if (step != STEP_FIRST)
      begin
         unique case (op)
            OP_PROGRAM:
               step_cmd = (step == STEP_SECOND) ? CMD_DEST_WR
                        : (step <= PROG_LAST_VAL_STEP) ? CMD_VAL_WR
                        : (step == PROG_PERM_STEP) ? CMD_PERM_WR : CMD_SELECT;
            OP_READ:
               step_cmd = (step <= READ_LAST_VAL_STEP) ? CMD_VAL_RD : CMD_SELECT;
            OP_EXPORT:
               step_cmd = (step == STEP_SECOND) ? CMD_EXPORT : CMD_SELECT;
            OP_REVOKE:
               step_cmd = (step == STEP_SECOND) ? CMD_PERM_WR : CMD_SELECT;
         endcase
      end
   endfunction : step_cmd

   host_state_t state_reg;
   host_op_t op_reg;
   logic [7:0] slot_reg;
   logic [2:0] step_reg;
   logic [31:0] dest_reg;
   logic [31:0] perm_reg;
   logic [31:0] data_reg [WORDS];
   logic pushed_reg;
   logic revoked_reg;
   logic error_reg;
   logic evt_got_reg;
   logic wb_ack_reg;

   wire wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
   wire wb_wr = wb_take & wb_we_i;
   wire idle = state_reg == H_IDLE;
   wire is_data = (wb_adr_i >= ADR_DATA0) && (wb_adr_i <= ADR_DATA_LAST);
   wire [1:0] data_sel = wb_adr_i[3:2];
   wire start = wb_wr && idle && (wb_adr_i == ADR_CTRL);
   wire stat_wr = wb_wr && (wb_adr_i == ADR_STAT);
   wire any_evt = kg.evt_pushed | kg.evt_revoked | kg.evt_error;
   wire cmd_t cur_cmd = step_cmd(op_reg, step_reg);
   wire last_step = (cur_cmd == CMD_SELECT) && (step_reg != STEP_FIRST);
   wire [2:0] word_base = (op_reg == OP_PROGRAM) ? PROG_WORD_BASE : READ_WORD_BASE;
   wire [1:0] word_idx = 2'(step_reg - word_base);
   // an unused target on a readable slot: drop export permission
   wire [31:0] perm_prog = ((dest_reg == ERASED_WORD) && perm_reg[PERM_READ_BIT])
                    ? (perm_reg & ~(ZERO_WORD | (32'h1 << PERM_EXPORT_BIT))) : perm_reg;
   wire [31:0] perm_revoke = ERASED_WORD & ~(32'h1 << PERM_LIVE_BIT);
   wire [31:0] status_word = {26'h0, error_reg, revoked_reg, pushed_reg,
                              kg.stat_blocked, kg.stat_selected, !idle};
   wire [31:0] rd_mux = (wb_adr_i == ADR_DEST) ? dest_reg
                      : (wb_adr_i == ADR_PERM) ? perm_reg
                      : (wb_adr_i == ADR_STAT) ? status_word
                      : (wb_adr_i == ADR_CTRL) ? {16'h0, slot_reg, 6'h0, op_reg}
                      : is_data ? data_reg[data_sel] : ZERO_WORD;

   // sequence engine; every sequence ends with a deselect
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_reg <= H_IDLE;
         op_reg <= OP_PROGRAM;
         slot_reg <= NO_SLOT;
         step_reg <= STEP_FIRST;
      end
      else
      begin
         unique case (state_reg)
            H_IDLE:
            begin
               if (start)
               begin
                  op_reg <= host_op_t'(wb_dat_i[CTRL_OP_LSB +: 2]);
                  slot_reg <= wb_dat_i[CTRL_SLOT_LSB +: 8];
                  step_reg <= STEP_FIRST;
                  state_reg <= H_REQ;
               end
            end
            H_REQ:
            begin
               if (kg.ack)
               begin
                  if (cur_cmd == CMD_EXPORT)
                     state_reg <= H_WAIT;
                  else if (last_step)
                     state_reg <= H_IDLE;
                  else
                     step_reg <= step_reg + 3'h1;
               end
            end
            H_WAIT:
            begin
               if (evt_got_reg | any_evt)
               begin
                  step_reg <= step_reg + 3'h1;
                  state_reg <= H_REQ;
               end
            end
            default:
               state_reg <= H_IDLE;
         endcase
      end
   end

   // sticky outcome flags; software clears by writing one, a new event wins
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         pushed_reg <= 1'b0;
         revoked_reg <= 1'b0;
         error_reg <= 1'b0;
         evt_got_reg <= 1'b0;
         wb_ack_reg <= 1'b0;
         dest_reg <= ERASED_WORD;
         perm_reg <= ERASED_WORD;
      end
      else
      begin
         wb_ack_reg <= wb_take;
         pushed_reg <= kg.evt_pushed | (pushed_reg & ~(stat_wr & wb_dat_i[STAT_PUSHED]));
         revoked_reg <= kg.evt_revoked | (revoked_reg & ~(stat_wr & wb_dat_i[STAT_REVOKED]));
         error_reg <= kg.evt_error | (error_reg & ~(stat_wr & wb_dat_i[STAT_ERROR]));
         if (any_evt)
            evt_got_reg <= 1'b1;
         else if ((state_reg == H_REQ) && kg.ack && (cur_cmd == CMD_EXPORT))
            evt_got_reg <= 1'b0;
         if (wb_wr && idle && (wb_adr_i == ADR_DEST))
            dest_reg <= merge_bytes(dest_reg, wb_dat_i, wb_sel_i);
         if (wb_wr && idle && (wb_adr_i == ADR_PERM))
            perm_reg <= merge_bytes(perm_reg, wb_dat_i, wb_sel_i);
      end
   end

   generate
      for (genvar g = 0; g < WORDS; g++)
      begin : g_data
         always_ff @(posedge sys_clk)
         begin
            if (!reset_n)
               data_reg[g] <= ERASED_WORD;
            else if ((state_reg == H_REQ) && kg.ack && (cur_cmd == CMD_VAL_RD) && (word_idx == 2'(g)))
               data_reg[g] <= kg.rdata;
            else if (wb_wr && idle && is_data && (data_sel == 2'(g)))
               data_reg[g] <= merge_bytes(data_reg[g], wb_dat_i, wb_sel_i);
         end
      end
   endgenerate

   assign wb_ack_o = wb_ack_reg;
   assign wb_dat_o = wb_ack_reg ? rd_mux : ZERO_WORD;

   assign kg.req = state_reg == H_REQ;
   assign kg.cmd = cur_cmd;
   assign kg.slot = last_step ? NO_SLOT : slot_reg;
   assign kg.word = word_idx;
   assign kg.wdata = (cur_cmd == CMD_DEST_WR) ? dest_reg
                   : (cur_cmd == CMD_VAL_WR) ? data_reg[word_idx]
                   : (cur_cmd == CMD_PERM_WR) ? ((op_reg == OP_REVOKE) ? perm_revoke : perm_prog)
                   : ZERO_WORD;
   // flash writing only for the span of a program or revoke sequence
   assign kg.flash_wen = !idle && ((op_reg == OP_PROGRAM) || (op_reg == OP_REVOKE));

endmodule : key_slot_host
`default_nettype wire
